// >>> dbc_defines.svh
// Purpose: Constants for the dual bridge current chopper.
// Assumes: clk runs at 250 MHz.
// Notes:   Cycle counts round up from the times in nanoseconds.
`ifndef DBC_DEFINES_SVH
`define DBC_DEFINES_SVH

// Clock rate and timer width.
`define DBC_CLK_MHZ    250
`define DBC_TMR_W      13

// Times in nanoseconds.
`define DBC_OFF_NS     30000
`define DBC_BLANK_NS   3000
`define DBC_DEAD_NS    300

// A least time in whole clock cycles, rounded up.
`define DBC_CYC(ns)    (((ns) * `DBC_CLK_MHZ + 999) / 1000)
`define DBC_OFF_CYC    `DBC_CYC(`DBC_OFF_NS)
`define DBC_BLANK_CYC  `DBC_CYC(`DBC_BLANK_NS)
`define DBC_DEAD_CYC   `DBC_CYC(`DBC_DEAD_NS)

// APB register byte offsets and reset values.
`define DBC_ADDR_W     12
`define DBC_CTRL_OFS   12'h000
`define DBC_STAT_OFS   12'h004
`define DBC_CTRL_RST   2'h3

// Switch pattern bits: high and low side of outputs a and b.
`define DBC_HSA        3
`define DBC_LSA        2
`define DBC_HSB        1
`define DBC_LSB        0

// Switch patterns.
`define DBC_PAT_FWD    4'h9
`define DBC_PAT_REV    4'h6
`define DBC_PAT_BRAKE  4'h5
`define DBC_PAT_OFF    4'h0

`endif

// >>> dbc_pkg.sv
// Purpose: Types shared by the dual bridge current chopper.
// Assumes: Constants come from dbc_defines.svh.
// Notes:   State structs of the top module live here.
package dbc_pkg;

  // Channel regulator state; CH_ON is the set PWM latch.
  typedef enum logic [1:0] {CH_STOP, CH_ON, CH_OFF} dbc_chan_e;

  // Four switches of one full bridge.
  typedef logic [3:0] dbc_pat_t;

  // Whole state of the top module.
  typedef struct packed {
    logic [1:0]             en;
    logic [31:0]            rdata;
    dbc_chan_e [1:0]        st;
    logic [1:0]             zc;
  } dbc_top_s;

endpackage

// >>> dbc_bridge_if.sv
// Purpose: Carries one bridge's wanted and applied switch patterns.
// Assumes: One instance per channel.
// Notes:   The deadband stage owns the applied pattern.
`timescale 1ns/1ps
interface dbc_bridge_if;
  dbc_pkg::dbc_pat_t desired;
  dbc_pkg::dbc_pat_t applied;
  modport ctl   (output desired, input applied);
  modport stage (input desired, output applied);
endinterface

// >>> dbc_oneshot.sv
// Purpose: Retriggerable one-shot timer.
// Assumes: load is a one-cycle pulse.
// Notes:   busy is high for exactly count cycles after load.
`timescale 1ns/1ps
module dbc_oneshot #(
  parameter int W = 13
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              busy
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } dbc_shot_s;

  dbc_shot_s q;
  dbc_shot_s d;

  // Load wins over the running count so a retrigger restarts cleanly.
  always_comb begin
    d = q;
    if (load) begin
      d.cnt = count;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy = (q.cnt != '0);
endmodule

// >>> dbc_deadband.sv
// Purpose: Applies a bridge switch pattern with crossover dead time.
// Assumes: The wanted pattern never sets both switches of a half.
// Notes:   Switches turn off at once; turn-on waits the dead time.
`timescale 1ns/1ps
`include "dbc_defines.svh"
module dbc_deadband (
  input  wire logic   clk,
  input  wire logic   nrst,
  dbc_bridge_if.stage bif
);
  typedef struct packed {
    logic [3:0] applied;
    logic [3:0] want;
    logic       waiting;
  } dbc_db_s;

  dbc_db_s q;
  dbc_db_s d;
  logic    dead_load;
  logic    dead_busy;

  dbc_oneshot #(.W(`DBC_TMR_W)) u_dead (
    .clk   (clk),
    .nrst  (nrst),
    .load  (dead_load),
    .count (13'(`DBC_DEAD_CYC)),
    .busy  (dead_busy)
  );

  // Drop removed switches now; a new switch waits a full dead time
  // after its partner went off, restarting if the target moves.
  always_comb begin
    d = q;
    dead_load = 1'b0;
    d.applied = q.applied & bif.desired;
    d.want = bif.desired;
    if ((bif.desired & ~q.applied) == '0) begin
      d.waiting = 1'b0;
    end else if (!q.waiting || bif.desired != q.want) begin
      dead_load = 1'b1;
      d.waiting = 1'b1;
    end else if (!dead_busy) begin
      d.applied = bif.desired;
      d.waiting = 1'b0;
    end
  end

  // State register; all switches off in reset.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bif.applied = q.applied;

  a_no_shoot_thru: assert property (
    @(posedge clk) disable iff (!nrst)
    !(q.applied[`DBC_HSA] && q.applied[`DBC_LSA]) &&
    !(q.applied[`DBC_HSB] && q.applied[`DBC_LSB]))
    else $error("Both switches of a half bridge are on.");

  a_dead_before_on: assert property (
    @(posedge clk) disable iff (!nrst)
    ((q.applied & ~$past(q.applied)) != '0) |-> $past(dead_busy, 2))
    else $error("A switch turned on without a dead interval.");
endmodule

// >>> dbc_chopper.sv
// Purpose: Dual full bridge fixed off-time PWM current chopper.
// Assumes: Comparator, zero-current and fault inputs are synchronous.
// Notes:   Switch enables leave through a deadband stage per bridge.
`timescale 1ns/1ps
`include "dbc_defines.svh"
module dbc_chopper #(
  parameter logic [12:0] OFF_CYCLES = 13'(`DBC_OFF_CYC)
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  direction_select,
  input  wire logic [1:0]  bridge_drive_gate,
  input  wire logic [1:0]  decay_select,
  input  wire logic [1:0]  trip_current_hit,
  input  wire logic [1:0]  zero_current,
  input  wire logic        thermal_fault,
  input  wire logic        pump_reservoir_low,
  input  wire logic        undervoltage_lockout,
  output logic [1:0]       bridge_output_a_hs,
  output logic [1:0]       bridge_output_a_ls,
  output logic [1:0]       bridge_output_b_hs,
  output logic [1:0]       bridge_output_b_ls
);

  dbc_pkg::dbc_top_s           q;
  dbc_pkg::dbc_top_s           d;
  dbc_pkg::dbc_pat_t [1:0]     pat;
  logic                        fault;
  logic [1:0]                  blocked;
  logic [1:0]                  off_load;
  logic [1:0]                  off_busy;
  logic [1:0]                  blank_load;
  logic [1:0]                  blank_busy;
  logic [1:0]                  st_on;
  logic [1:0]                  st_off;
  logic                        setup;
  logic                        access;
  logic                        hit_ctrl;
  logic                        hit_stat;

  // Diagonal drive pattern for a direction level.
  function automatic dbc_pkg::dbc_pat_t drive_pat(input logic dir);
    drive_pat = dir ? `DBC_PAT_FWD : `DBC_PAT_REV;
  endfunction

  // Any fault source stops every bridge; no latching, so drive
  // resumes by itself once the source clears.
  assign fault = thermal_fault | pump_reservoir_low |
                 undervoltage_lockout;

  // APB decode; the slave never waits.
  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign hit_ctrl = (paddr == `DBC_CTRL_OFS);
  assign hit_stat = (paddr == `DBC_STAT_OFS);
  assign pready   = 1'b1;
  assign pslverr  = access && !(hit_ctrl || hit_stat);
  assign prdata   = q.rdata;

  // State summaries for the status register.
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      st_on[c]  = (q.st[c] == dbc_pkg::CH_ON);
      st_off[c] = (q.st[c] == dbc_pkg::CH_OFF);
    end
  end

  // Next state: APB, then each channel's regulator and pattern.
  always_comb begin
    d = q;
    off_load = 2'h0;
    blank_load = 2'h0;
    pat = '0;
    blocked = 2'h0;

    // Read data is captured in setup, so it is stable in access.
    if (setup) begin
      if (hit_ctrl) begin
        d.rdata = {30'h0, q.en};
      end else if (hit_stat) begin
        d.rdata = {25'h0, fault, q.zc, st_off, st_on};
      end else begin
        d.rdata = 32'h0;
      end
    end
    if (access && pwrite && hit_ctrl) begin
      d.en = pwdata[1:0];
    end

    // Both channels run the same code with no shared state.
    for (int c = 0; c < 2; c++) begin
      blocked[c] = fault | ~q.en[c];
      case (q.st[c])
        dbc_pkg::CH_STOP: begin
          // Start an on phase; the switching starts blanking.
          if (!blocked[c] && bridge_drive_gate[c]) begin
            d.st[c] = dbc_pkg::CH_ON;
            d.zc[c] = 1'b0;
            blank_load[c] = 1'b1;
          end
        end
        dbc_pkg::CH_ON: begin
          if (blocked[c] || !bridge_drive_gate[c]) begin
            d.st[c] = dbc_pkg::CH_STOP;
          end else if (trip_current_hit[c] && !blank_busy[c]) begin
            // Latch reset: high side off, off timer runs.
            d.st[c] = dbc_pkg::CH_OFF;
            off_load[c] = 1'b1;
            blank_load[c] = 1'b1;
          end
        end
        dbc_pkg::CH_OFF: begin
          if (blocked[c] || !bridge_drive_gate[c]) begin
            d.st[c] = dbc_pkg::CH_STOP;
          end else if (!off_busy[c]) begin
            // Timer expired: set the latch again.
            d.st[c] = dbc_pkg::CH_ON;
            d.zc[c] = 1'b0;
            blank_load[c] = 1'b1;
          end
        end
        default: begin
          d.st[c] = dbc_pkg::CH_STOP;
        end
      endcase

      // Zero crossing seen during any decay stays until next on phase.
      if (d.st[c] != dbc_pkg::CH_ON && zero_current[c]) begin
        d.zc[c] = 1'b1;
      end

      // Switch pattern for this channel.
      if (blocked[c]) begin
        pat[c] = `DBC_PAT_OFF;
      end else if (q.st[c] == dbc_pkg::CH_ON) begin
        pat[c] = drive_pat(direction_select[c]);
      end else if (q.st[c] == dbc_pkg::CH_OFF ||
                   !bridge_drive_gate[c]) begin
        if (decay_select[c]) begin
          // Slow decay: both low sides conduct. The brake holds while
          // the gate is low, so back-EMF stays shorted.
          if (q.st[c] == dbc_pkg::CH_STOP) begin
            pat[c] = `DBC_PAT_BRAKE;
          end else if (!q.zc[c]) begin
            pat[c] = `DBC_PAT_BRAKE;
          end else begin
            pat[c] = `DBC_PAT_OFF;
          end
        end else if (!q.zc[c]) begin
          // Fast decay: inverse of the on-phase drive for this direction.
          pat[c] = drive_pat(~direction_select[c]);
        end else begin
          pat[c] = `DBC_PAT_OFF;
        end
      end else begin
        pat[c] = `DBC_PAT_OFF;
      end
    end
  end

  // State register; channels stopped, both enabled after reset.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q.en    <= `DBC_CTRL_RST;
      q.rdata <= 32'h0;
      q.st    <= '{dbc_pkg::CH_STOP, dbc_pkg::CH_STOP};
      q.zc    <= 2'h0;
    end else begin
      q <= d;
    end
  end

  dbc_bridge_if bif [2] ();

  // Per-bridge timers, deadband stage and checks.
  for (genvar c = 0; c < 2; c++) begin : g_ch
    dbc_oneshot #(.W(`DBC_TMR_W)) u_off (
      .clk   (clk),
      .nrst  (nrst),
      .load  (off_load[c]),
      .count (OFF_CYCLES),
      .busy  (off_busy[c])
    );

    dbc_oneshot #(.W(`DBC_TMR_W)) u_blank (
      .clk   (clk),
      .nrst  (nrst),
      .load  (blank_load[c]),
      .count (13'(`DBC_BLANK_CYC)),
      .busy  (blank_busy[c])
    );

    dbc_deadband u_db (
      .clk  (clk),
      .nrst (nrst),
      .bif  (bif[c])
    );

    // Switch enables come straight from the deadband flip-flops.
    assign bif[c].desired       = pat[c];
    assign bridge_output_a_hs[c] = bif[c].applied[`DBC_HSA];
    assign bridge_output_a_ls[c] = bif[c].applied[`DBC_LSA];
    assign bridge_output_b_hs[c] = bif[c].applied[`DBC_HSB];
    assign bridge_output_b_ls[c] = bif[c].applied[`DBC_LSB];

    // The wanted pattern must drop the sourcing high side at once;
    // 4'hA masks the two high-side switches of a pattern.
    a_trip_to_off: assert property (
      @(posedge clk) disable iff (!nrst)
      (q.st[c] == dbc_pkg::CH_ON && trip_current_hit[c] &&
       !blank_busy[c] && !blocked[c] && bridge_drive_gate[c])
      |=> q.st[c] == dbc_pkg::CH_OFF && off_busy[c] &&
          (pat[c] & drive_pat(direction_select[c]) &
           4'hA) == 4'h0)
      else $error("Trip did not end the on phase.");

    a_off_holds: assert property (
      @(posedge clk) disable iff (!nrst)
      (q.st[c] == dbc_pkg::CH_OFF && off_busy[c])
      |-> (d.st[c] != dbc_pkg::CH_ON))
      else $error("Drive resumed before the off time ended.");

    a_blank_ignore: assert property (
      @(posedge clk) disable iff (!nrst)
      $rose(q.st[c] == dbc_pkg::CH_ON) |-> blank_busy[c] [*8])
      else $error("Sense blanking missing after switching.");

    a_expiry_drive: assert property (
      @(posedge clk) disable iff (!nrst)
      (q.st[c] == dbc_pkg::CH_OFF && !off_busy[c] &&
       !blocked[c] && bridge_drive_gate[c])
      |=> q.st[c] == dbc_pkg::CH_ON ##1 blank_busy[c])
      else $error("Off timer expiry did not restart drive.");

    a_fault_off: assert property (
      @(posedge clk) disable iff (!nrst)
      (thermal_fault || pump_reservoir_low)
      |=> !bridge_output_a_hs[c] && !bridge_output_a_ls[c] &&
          !bridge_output_b_hs[c] && !bridge_output_b_ls[c])
      else $error("Outputs stayed on during a fault.");

    a_undervoltage_lockout_off: assert property (
      @(posedge clk) disable iff (!nrst)
      undervoltage_lockout [*2]
      |-> q.st[c] == dbc_pkg::CH_STOP && pat[c] == `DBC_PAT_OFF)
      else $error("Drivers active under lockout.");

    a_direction: assert property (
      @(posedge clk) disable iff (!nrst)
      (q.st[c] == dbc_pkg::CH_ON &&
       $past(q.st[c]) == dbc_pkg::CH_ON &&
       $stable(direction_select[c]))
      |-> !(bridge_output_a_hs[c] && !direction_select[c]) &&
          !(bridge_output_b_hs[c] && direction_select[c]))
      else $error("Drive disagrees with the direction input.");

    a_brake_both_low: assert property (
      @(posedge clk) disable iff (!nrst)
      (q.st[c] == dbc_pkg::CH_STOP && !blocked[c] &&
       !bridge_drive_gate[c] && decay_select[c])
      |-> pat[c] == `DBC_PAT_BRAKE)
      else $error("Brake did not drive both outputs low.");

    a_zero_cut: assert property (
      @(posedge clk) disable iff (!nrst)
      (q.st[c] != dbc_pkg::CH_ON && zero_current[c] && !blocked[c] &&
       !(!bridge_drive_gate[c] && decay_select[c]))
      ##1 $stable(decay_select[c])
      |-> (q.st[c] == dbc_pkg::CH_ON) || pat[c] == `DBC_PAT_OFF)
      else $error("Rectification stayed on after zero current.");

    // Pattern and regulator checks; each watches this channel only,
    // so a fault in one regulator cannot hide behind the other.
    a_on_diagonal: assert property (
      @(posedge clk) disable iff (!nrst)
      (q.st[c] == dbc_pkg::CH_ON && !blocked[c])
      |-> pat[c] == (direction_select[c] ? `DBC_PAT_FWD : `DBC_PAT_REV))
      else $error("On phase did not drive a diagonal pair.");

    a_stop_start: assert property (
      @(posedge clk) disable iff (!nrst)
      (q.st[c] == dbc_pkg::CH_STOP && !blocked[c] &&
       bridge_drive_gate[c])
      |=> q.st[c] == dbc_pkg::CH_ON && blank_busy[c])
      else $error("Gate high did not start a blanked on phase.");

    a_slow_brake: assert property (
      @(posedge clk) disable iff (!nrst)
      (q.st[c] == dbc_pkg::CH_OFF && !blocked[c] && decay_select[c] &&
       !q.zc[c])
      |-> pat[c] == `DBC_PAT_BRAKE)
      else $error("Slow decay did not short through the low sides.");

    a_fast_inverse: assert property (
      @(posedge clk) disable iff (!nrst)
      (q.st[c] != dbc_pkg::CH_ON && !blocked[c] && !decay_select[c] &&
       !q.zc[c] && (q.st[c] == dbc_pkg::CH_OFF || !bridge_drive_gate[c]))
      |-> pat[c] == (direction_select[c] ? `DBC_PAT_REV : `DBC_PAT_FWD))
      else $error("Fast decay did not reverse the drive.");

    a_zero_sticky: assert property (
      @(posedge clk) disable iff (!nrst)
      (q.zc[c] && d.st[c] != dbc_pkg::CH_ON) |=> q.zc[c])
      else $error("Zero-current flag cleared during decay.");

    a_blocked_stop: assert property (
      @(posedge clk) disable iff (!nrst)
      blocked[c] |=> q.st[c] == dbc_pkg::CH_STOP)
      else $error("Regulator kept running while blocked.");

    a_off_entry_busy: assert property (
      @(posedge clk) disable iff (!nrst)
      $rose(q.st[c] == dbc_pkg::CH_OFF) |-> off_busy[c])
      else $error("Off phase began without its timer.");

    a_trip_blanked: assert property (
      @(posedge clk) disable iff (!nrst)
      (q.st[c] == dbc_pkg::CH_ON && blank_busy[c] && !blocked[c] &&
       bridge_drive_gate[c])
      |=> q.st[c] == dbc_pkg::CH_ON)
      else $error("Sense trip acted inside the blanking time.");
  end

endmodule

// >>> dbc_host_model.sv
// Purpose: Host model driving the direction, gate and decay pins.
// Assumes: The testbench sets the wanted levels one cycle ahead.
// Notes:   Chopping toggles the gate every HALF cycles.
`timescale 1ns/1ps
module dbc_host_model #(
  parameter int HALF = 300
) (
  input  wire logic [1:0] set_dir,
  input  wire logic [1:0] set_gate,
  input  wire logic [1:0] set_decay,
  input  wire logic [1:0] chop,
  input  wire logic       clk,
  output logic [1:0]      direction_select,
  output logic [1:0]      bridge_drive_gate,
  output logic [1:0]      decay_select
);
  int cnt;

  // Pins start low so the bridge powers up idle.
  initial begin
    cnt = 0;
    direction_select = 2'h0;
    bridge_drive_gate = 2'h0;
    decay_select = 2'h0;
  end

  // Pins change only just after an edge, like a clocked host port.
  always @(posedge clk) begin
    cnt <= (cnt >= HALF - 1) ? 0 : cnt + 1;
    direction_select <= set_dir;
    decay_select <= set_decay;
    for (int c = 0; c < 2; c++) begin
      if (!chop[c])
        bridge_drive_gate[c] <= set_gate[c];
      else if (cnt == 0)
        bridge_drive_gate[c] <= ~bridge_drive_gate[c];
    end
  end
endmodule

// >>> dbc_chopper_tb.sv
// Purpose: Self-checking bench for the dual bridge current chopper.
// Assumes: A short off interval; blank and dead times stay fixed.
// Notes:   Comparator and zero-current levels are driven directly.
`timescale 1ns/1ps
`include "dbc_defines.svh"
module dbc_chopper_tb;
  localparam int OFF = 200;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  s_dir, s_gate, s_decay, chop, trip, zc;
  logic [1:0]  dir, gate, decay, ahs, als, bhs, bls;
  logic [2:0]  flt;
  int          error_cnt, compares, cyc;

  dbc_chopper #(.OFF_CYCLES(13'(OFF))) i_dbc_chopper (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .direction_select(dir),
    .bridge_drive_gate(gate), .decay_select(decay),
    .trip_current_hit(trip), .zero_current(zc),
    .thermal_fault(flt[0]), .pump_reservoir_low(flt[1]),
    .undervoltage_lockout(flt[2]), .bridge_output_a_hs(ahs),
    .bridge_output_a_ls(als), .bridge_output_b_hs(bhs),
    .bridge_output_b_ls(bls));

  dbc_host_model i_dbc_host_model (
    .set_dir(s_dir), .set_gate(s_gate), .set_decay(s_decay),
    .chop(chop), .clk(clk), .direction_select(dir),
    .bridge_drive_gate(gate), .decay_select(decay));

  // Free clock and a cycle count for interval checks.
  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // Both switches of one half must never conduct together.
  always @(posedge clk) begin
    if (nrst && ((ahs & als) | (bhs & bls)) != 2'h0)
      chk("overlap", 32'h0, 32'h1);
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  function automatic dbc_pkg::dbc_pat_t pat(input int c);
    return {ahs[c], als[c], bhs[c], bls[c]};
  endfunction

  // Waits for a switch pattern; mn is the least delay allowed.
  task automatic wait_pat(input int c, input dbc_pkg::dbc_pat_t p,
                          input int lim, input int mn);
    int n;
    n = 0;
    while (pat(c) !== p && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk($sformatf("pattern ch%0d", c), 32'(p), 32'(pat(c)));
    if (mn > 0)
      chk("turn-on delay", 32'h1, 32'(n >= mn));
  endtask

  task automatic wait_gate(input logic v);
    int n;
    n = 0;
    while (gate[0] !== v && n < 700) begin
      @(posedge clk);
      n++;
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic        e;
    chk("reset outputs", 32'h0, 32'({ahs, als, bhs, bls}));
    chk("ready", 32'h1, 32'(pready));
    apb(1'h0, `DBC_CTRL_OFS, 32'h0, d, e);
    chk("ctrl reset", 32'h3, d);
    apb(1'h0, 12'h008, 32'h0, d, e);
    chk("unmapped error", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, d);
    apb(1'h1, `DBC_STAT_OFS, 32'hFFFFFFFF, d, e);
    chk("status write error", 32'h0, 32'(e));
    apb(1'h1, `DBC_CTRL_OFS, 32'h2, d, e);
    s_gate <= 2'h3;
    repeat (100) @(posedge clk);
    chk("disabled ch0", 32'h0, 32'(pat(0)));
    chk("reverse ch1", 32'(`DBC_PAT_REV), 32'(pat(1)));
    apb(1'h1, `DBC_CTRL_OFS, 32'h3, d, e);
    wait_pat(0, `DBC_PAT_FWD, 100, `DBC_DEAD_CYC);
    apb(1'h0, `DBC_STAT_OFS, 32'h0, d, e);
    chk("on phases", 32'h3, d & 32'h3);
  endtask

  task automatic t_trips();
    logic [31:0] d;
    logic        e;
    int          t0;
    trip <= 2'h1;
    repeat (20) @(posedge clk);
    trip <= 2'h0;
    repeat (5) @(posedge clk);
    chk("blanked trip", 32'(`DBC_PAT_FWD), 32'(pat(0)));
    repeat (`DBC_BLANK_CYC) @(posedge clk);
    t0 = cyc;
    trip <= 2'h1;
    @(posedge clk);
    trip <= 2'h0;
    repeat (3) @(posedge clk);
    chk("source off", 32'h0, 32'(ahs[0]));
    wait_pat(0, `DBC_PAT_BRAKE, 100, 0);
    apb(1'h0, `DBC_STAT_OFS, 32'h0, d, e);
    chk("off phase", 32'h4, d & 32'hC);
    chk("other channel", 32'(`DBC_PAT_REV), 32'(pat(1)));
    wait_pat(0, `DBC_PAT_FWD, 400, 0);
    chk("off time", 32'h1, 32'(cyc - t0 >= OFF &&
        cyc - t0 <= OFF + `DBC_DEAD_CYC + 10));
    s_decay <= 2'h2;
    repeat (`DBC_BLANK_CYC) @(posedge clk);
    trip <= 2'h1;
    @(posedge clk);
    trip <= 2'h0;
    wait_pat(0, `DBC_PAT_REV, 100, 0);
    zc <= 2'h1;
    repeat (3) @(posedge clk);
    chk("zero cut", 32'h0, 32'(pat(0)));
    zc <= 2'h0;
    apb(1'h0, `DBC_STAT_OFS, 32'h0, d, e);
    chk("zero seen", 32'h10, d & 32'h10);
    wait_pat(0, `DBC_PAT_FWD, 400, 0);
  endtask

  // Fast decay is tried first, as the zero flag holds until next on.
  task automatic t_gate_low();
    s_gate <= 2'h2;
    wait_pat(0, `DBC_PAT_REV, 100, 0);
    zc <= 2'h1;
    repeat (3) @(posedge clk);
    chk("fast zero", 32'h0, 32'(pat(0)));
    zc <= 2'h0;
    s_decay <= 2'h3;
    wait_pat(0, `DBC_PAT_BRAKE, 100, 0);
    zc <= 2'h1;
    repeat (5) @(posedge clk);
    chk("brake kept", 32'(`DBC_PAT_BRAKE), 32'(pat(0)));
    zc <= 2'h0;
  endtask

  task automatic t_chop();
    s_gate <= 2'h3;
    chop <= 2'h1;
    wait_gate(1'h0);
    wait_gate(1'h1);
    repeat (100) @(posedge clk);
    chk("chop drive", 32'(`DBC_PAT_FWD), 32'(pat(0)));
    wait_gate(1'h0);
    repeat (100) @(posedge clk);
    chk("chop brake", 32'(`DBC_PAT_BRAKE), 32'(pat(0)));
    chop <= 2'h0;
  endtask

  task automatic t_fault();
    logic [31:0] d;
    logic        e;
    for (int i = 0; i < 3; i++) begin
      wait_pat(0, `DBC_PAT_FWD, 400, 0);
      flt <= 3'(1 << i);
      repeat (3) @(posedge clk);
      chk("fault off", 32'h0, 32'({ahs, als, bhs, bls}));
      apb(1'h0, `DBC_STAT_OFS, 32'h0, d, e);
      chk("fault flag", 32'h40, d & 32'h40);
      repeat (50) @(posedge clk);
      chk("fault held", 32'h0, 32'({ahs, als, bhs, bls}));
      flt <= 3'h0;
    end
    wait_pat(0, `DBC_PAT_FWD, 100, `DBC_DEAD_CYC);
    apb(1'h0, `DBC_STAT_OFS, 32'h0, d, e);
    chk("fault clear", 32'h1, d & 32'h41);
  endtask

  task automatic print_verdict();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence: reset for eight cycles, then every scenario.
  initial begin
    clk = 1'h0;
    nrst = 1'h0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {s_gate, chop, trip, zc, flt} = '0;
    s_dir = 2'h1;
    s_decay = 2'h3;
    error_cnt = 0;
    compares = 0;
    cyc = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    t_regs();
    t_trips();
    t_gate_low();
    t_chop();
    t_fault();
    print_verdict();
  end

  // Watchdog: more than five times the expected run length.
  initial begin
    #80000;
    error_cnt++;
    $display("ERROR watchdog expected finish seen timeout");
    print_verdict();
  end
endmodule
